// File: hdl/fp_core_ctrl.sv
/*
 core end: apb slave driving the link, access control and interrupt bits.
 assumes apb master on pclk; link status taken from the register end.
*/
`timescale 1ns/1ps
module fp_core_ctrl (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [fp_status_pkg::addr_w-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link
	fp_link_if.core link,
	// context control out
	output logic lazy_save_enable,
	output logic auto_save_enable,
	output logic per_flag_masks,
	output logic [1:0] coproc_ten_access,
	output logic [1:0] coproc_eleven_access,
	// irq
	output logic irq
);
	import fp_status_pkg::*;
	logic [31:0] ctrl_q, irq_st_q, irq_mask_q, rdata_q;
	logic prev_en_q;
	wire acc_w = psel && penable;
	wire wr_w = acc_w && pwrite && clk_en;
	wire rd_w = acc_w && !pwrite && clk_en;
	wire hit_ctrl = paddr == off_ctrl;
	wire hit_fpscr = paddr == off_fpscr;
	wire hit_ist = paddr == off_irq_status;
	wire hit_imask = paddr == off_irq_mask;
	wire hit_evt = paddr == off_event;
	wire hit_stat = paddr == off_status;
	wire known_w = hit_ctrl | hit_fpscr | hit_ist | hit_imask | hit_evt | hit_stat;
	// event: unit enable rose
	wire ev_en = link.fp_enabled && !prev_en_q;
	assign pready = 1'b1;
	assign pslverr = acc_w && !known_w;
	assign prdata = rdata_q;
	assign lazy_save_enable = ctrl_q[ctl_lazy];
	assign auto_save_enable = ctrl_q[ctl_auto];
	assign per_flag_masks = ctrl_q[ctl_permask];
	assign coproc_ten_access = ctrl_q[ctl_coproc_ten_access_lo+1:ctl_coproc_ten_access_lo];
	assign coproc_eleven_access = ctrl_q[ctl_coproc_eleven_access_lo+1:ctl_coproc_eleven_access_lo];
	assign link.xfer_wr = wr_w && hit_fpscr;
	assign link.xfer_rd = rd_w && hit_fpscr;
	assign link.xfer_wdata = pwdata;
	assign link.cmp_valid = wr_w && hit_evt && pwdata[8];
	assign link.cmp_result = pwdata[1:0];
	assign link.exc_valid = wr_w && hit_evt && pwdata[9];
	assign link.exc_flags = pwdata[23:16];
	assign irq = |(irq_st_q & irq_mask_q);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_q <= reset_zero;
			irq_mask_q <= reset_zero;
			irq_st_q <= reset_zero;
			prev_en_q <= 1'b0;
			rdata_q <= reset_zero;
		end
		else if (clk_en)
		begin
			prev_en_q <= link.fp_enabled;
			if (wr_w && hit_ctrl)
				ctrl_q <= pwdata;
			if (wr_w && hit_imask)
				irq_mask_q <= pwdata;
			// set wins over write-one clear
			irq_st_q[irq_flag] <= (irq_st_q[irq_flag] && !(wr_w && hit_ist && pwdata[irq_flag]))
				|| ev_en;
			if (rd_w)
				rdata_q <= hit_ctrl ? ctrl_q : hit_fpscr ? link.xfer_rdata :
					hit_ist ? irq_st_q : hit_imask ? irq_mask_q :
					hit_stat ? link.status_word : reset_zero;
		end
	end
endmodule

// File: hdl/fp_link_if.sv
/*
 interface between the fp register block and its core-side controller.
 assumes one clock, pclk, shared by both ends.
*/
`timescale 1ns/1ps
interface fp_link_if;
	logic cmp_valid;
	logic [1:0] cmp_result;
	logic [7:0] exc_flags;
	logic exc_valid;
	logic xfer_wr;
	logic xfer_rd;
	logic [31:0] xfer_wdata;
	logic [31:0] xfer_rdata;
	logic fp_enabled;
	logic [31:0] status_word;
	modport device (
		input cmp_valid, cmp_result, exc_flags, exc_valid, xfer_wr, xfer_rd, xfer_wdata,
		output xfer_rdata, fp_enabled, status_word
	);
	modport core (
		output cmp_valid, cmp_result, exc_flags, exc_valid, xfer_wr, xfer_rd, xfer_wdata,
		input xfer_rdata, fp_enabled, status_word
	);
endinterface

// File: hdl/fp_status_pkg.sv
/*
 fp status and context register block: shared constants and types.
 assumes both ends run on pclk with presetn, 200 MHz.
*/
package fp_status_pkg;
	localparam int unsigned data_w = 32;
	localparam int unsigned addr_w = 8;
	// apb offsets
	localparam logic [7:0] off_ctrl = 8'h00;
	localparam logic [7:0] off_status = 8'h04;
	localparam logic [7:0] off_context_address = 8'h08;
	localparam logic [7:0] off_default_status = 8'h0c;
	localparam logic [7:0] off_fpscr = 8'h10;
	localparam logic [7:0] off_irq_status = 8'h14;
	localparam logic [7:0] off_irq_mask = 8'h18;
	localparam logic [7:0] off_event = 8'h1c;
	localparam logic [31:0] reset_zero = 32'h0000_0000;
	localparam logic [31:0] addr_keep = 32'hffff_fff8;
	localparam logic [31:0] dflt_keep = 32'h07c0_0000;
	localparam logic [31:0] fpscr_keep = 32'hf7c0_009f;
	localparam logic [31:0] flag_keep = 32'h0000_009f;
	localparam logic [31:0] no_mask_flags = 32'h0000_008f;
	localparam int unsigned bit_n = 31;
	localparam int unsigned bit_z = 30;
	localparam int unsigned bit_c = 29;
	localparam int unsigned bit_v = 28;
	localparam int unsigned bit_ahp = 26;
	localparam int unsigned bit_dn = 25;
	localparam int unsigned bit_fz = 24;
	localparam int unsigned bit_rm_hi = 23;
	localparam int unsigned bit_rm_lo = 22;
	localparam int unsigned bit_ixc = 4;
	// ctrl register fields
	localparam int unsigned ctl_coproc_ten_access_lo = 20;
	localparam int unsigned ctl_coproc_eleven_access_lo = 22;
	localparam int unsigned ctl_lazy = 30;
	localparam int unsigned ctl_auto = 31;
	localparam int unsigned ctl_permask = 0;
	localparam logic [1:0] access_full = 2'h3;
	// irq layout: bit0 unit enable event
	localparam int unsigned irq_flag = 0;
	typedef enum logic [1:0] {cmp_eq, cmp_lt, cmp_gt, cmp_un} cmp_t;
	typedef enum logic [1:0] {rnd_near, rnd_plus, rnd_minus, rnd_zero} round_t;
	localparam logic [3:0] nzcv_eq = 4'h6;
	localparam logic [3:0] nzcv_lt = 4'h8;
	localparam logic [3:0] nzcv_gt = 4'h2;
	localparam logic [3:0] nzcv_un = 4'h3;
endpackage

// File: hdl/fp_status_regs.sv
/*
 device end: status/control, default status held at reset zero, context address, flag irq.
 assumes the core end drives the link on pclk; reached by the link, except the context address, which frame_alloc loads from frame_addr.
*/
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module fp_status_regs (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// link to core
	fp_link_if.device link,
	// context control from core
	input wire logic lazy_save_enable,
	input wire logic auto_save_enable,
	input wire logic per_flag_masks,
	input wire logic [1:0] coproc_ten_access,
	input wire logic [1:0] coproc_eleven_access,
	// frame allocation
	input wire logic frame_alloc,
	input wire logic [31:0] frame_addr,
	// decoded controls
	output logic alt_half_precision,
	output logic default_nan_mode,
	output logic flush_to_zero,
	output fp_status_pkg::round_t rounding_select,
	// flag interrupt
	input wire logic [7:0] system_config_block,
	output logic fp_irq
);
	import fp_status_pkg::*;
	logic [31:0] fpscr_q, fpscr_d;
	logic [31:0] context_address_q;
	logic [31:0] default_status_q;
	logic [7:0] sticky_set;
	logic [3:0] nzcv;
	logic [7:0] irq_mask;
	wire enabled_w = (coproc_ten_access == access_full) && (coproc_eleven_access == access_full);
	wire save_mode_w = lazy_save_enable | auto_save_enable;
	wire any_save_rd_w = link.xfer_rd && save_mode_w;
	always_comb
	begin
		case (link.cmp_result)
			cmp_eq: nzcv = nzcv_eq;
			cmp_lt: nzcv = nzcv_lt;
			cmp_gt: nzcv = nzcv_gt;
			cmp_un: nzcv = nzcv_un;
			default: nzcv = nzcv_un;
		endcase
	end
	assign sticky_set = link.exc_valid ? (link.exc_flags & flag_keep[7:0]) : 8'h00;
	always_comb
	begin
		fpscr_d = fpscr_q;
		if (link.xfer_wr)
			fpscr_d = link.xfer_wdata & fpscr_keep;
		if (any_save_rd_w)
			fpscr_d = fpscr_d & ~flag_keep;
		if (link.cmp_valid && enabled_w)
			fpscr_d[bit_n:bit_v] = nzcv;
		if (enabled_w)
			fpscr_d[7:0] = fpscr_d[7:0] | sticky_set;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fpscr_q <= reset_zero;
		else if (clk_en)
			fpscr_q <= fpscr_d;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			context_address_q <= reset_zero;
		else if (clk_en && frame_alloc)
			context_address_q <= frame_addr & addr_keep;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			default_status_q <= reset_zero;
		else if (clk_en && frame_alloc)
			default_status_q <= default_status_q;
	end
	assign alt_half_precision = fpscr_q[bit_ahp];
	assign default_nan_mode = fpscr_q[bit_dn];
	assign flush_to_zero = fpscr_q[bit_fz];
	assign rounding_select = round_t'(fpscr_q[bit_rm_hi:bit_rm_lo]);
	// per flag mask or inexact dropped
	assign irq_mask = per_flag_masks ? system_config_block : (no_mask_flags[7:0]);
	assign fp_irq = |(fpscr_q[7:0] & irq_mask & flag_keep[7:0]);
	assign link.fp_enabled = enabled_w;
	assign link.xfer_rdata = fpscr_q;
	assign link.status_word = {context_address_q[31:3], 3'h0} ^ default_status_q ^ default_status_q;
endmodule

// File: sim/fp_link_asserts.sv
/* link checker: compare flags, sticky flags, context address.
 assumes link signals on pclk, presetn low resets. */
`timescale 1ns/1ps
module fp_link_asserts (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link
	input wire logic cmp_valid,
	input wire logic [1:0] cmp_result,
	input wire logic [7:0] exc_flags,
	input wire logic exc_valid,
	input wire logic xfer_wr,
	input wire logic xfer_rd,
	input wire logic [31:0] xfer_wdata,
	input wire logic [31:0] xfer_rdata,
	input wire logic fp_enabled,
	input wire logic [31:0] status_word
);
	import fp_status_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire idle = !xfer_wr && !xfer_rd;
	wire go = cmp_valid && fp_enabled && !xfer_wr;
	addr_low_zero_a: assert property (status_word[2:0] == 3'h0)
		else $error("context address low bits set");
	cmp_equal_a: assert property (go && cmp_result == 2'h0 |=> xfer_rdata[31:28] == nzcv_eq)
		else $error("equal flags wrong");
	cmp_less_a: assert property (go && cmp_result == 2'h1 |=> xfer_rdata[31:28] == nzcv_lt)
		else $error("less flags wrong");
	cmp_greater_a: assert property (go && cmp_result == 2'h2 |=> xfer_rdata[31:28] == nzcv_gt)
		else $error("greater flags wrong");
	cmp_unord_a: assert property (go && cmp_result == 2'h3 |=> xfer_rdata[31:28] == nzcv_un)
		else $error("unordered flags wrong");
	cmp_off_a: assert property (cmp_valid && !fp_enabled && idle && !exc_valid |=> $stable(xfer_rdata))
		else $error("disabled unit changed status");
	flag_set_a: assert property (exc_valid && fp_enabled && idle
		|=> (xfer_rdata[7:0] & $past(exc_flags) & 8'h9f) == ($past(exc_flags) & 8'h9f))
		else $error("exception flag not set");
	flag_hold_a: assert property (idle
		|=> (xfer_rdata & $past(xfer_rdata) & flag_keep) == ($past(xfer_rdata) & flag_keep))
		else $error("sticky flag dropped");
	write_take_a: assert property (xfer_wr && fp_enabled && !exc_valid && !cmp_valid
		|=> (xfer_rdata & fpscr_keep) == ($past(xfer_wdata) & fpscr_keep))
		else $error("status write lost");
	rsvd_zero_a: assert property ((xfer_rdata & ~fpscr_keep) == 32'h0)
		else $error("reserved status bit set");
endmodule

// File: sim/test_fp_status_context_regs.sv
/* bench: both ends over the link, apb master, verdict.
 assumes pready arrives inside the watchdog span. */
`timescale 1ns/1ps
module test_fp_status_context_regs;
	import fp_status_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, frame_alloc = 1'b0;
	logic [7:0] paddr = 8'h0, system_config_block = 8'h0;
	logic [31:0] pwdata = 32'h0, frame_addr = 32'h0, rd, prdata;
	logic pready, pslverr, irq, fp_irq, err, lazy_save_enable, auto_save_enable, per_flag_masks;
	logic alt_half_precision, default_nan_mode, flush_to_zero;
	logic [1:0] coproc_ten_access, coproc_eleven_access;
	round_t rounding_select;
	logic [3:0] nzcv [4] = '{nzcv_eq, nzcv_lt, nzcv_gt, nzcv_un};
	int n_mismatch = 0, check_count = 0;
	fp_link_if link();
	fp_status_regs i_fp_status_regs (.pclk, .presetn, .clk_en(1'b1), .link, .lazy_save_enable,
		.auto_save_enable, .per_flag_masks, .coproc_ten_access, .coproc_eleven_access,
		.frame_alloc, .frame_addr, .alt_half_precision, .default_nan_mode, .flush_to_zero,
		.rounding_select, .system_config_block, .fp_irq);
	fp_core_ctrl i_fp_core_ctrl (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .link, .lazy_save_enable, .auto_save_enable,
		.per_flag_masks, .coproc_ten_access, .coproc_eleven_access, .irq);
	fp_link_asserts i_fp_link_asserts (.pclk, .presetn, .cmp_valid(link.cmp_valid),
		.cmp_result(link.cmp_result), .exc_flags(link.exc_flags), .exc_valid(link.exc_valid),
		.xfer_wr(link.xfer_wr), .xfer_rd(link.xfer_rd), .xfer_wdata(link.xfer_wdata),
		.xfer_rdata(link.xfer_rdata), .fp_enabled(link.fp_enabled), .status_word(link.status_word));
	initial forever #2.5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// read data lags the access edge by one cycle
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		err = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
		rd = prdata;
		repeat (2) @(posedge pclk);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0);
		chk(rd, exp, what);
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge pclk);
		n_mismatch++;
		give_verdict();
	end
	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(off_fpscr, reset_zero, "status reset");
		frame_alloc <= 1'b1;
		frame_addr <= 32'h2000_1237;
		@(posedge pclk);
		frame_alloc <= 1'b0;
		rd_chk(off_status, 32'h2000_1230, "context address");
		apb(1'b1, off_event, 32'h100);
		rd_chk(off_fpscr, reset_zero, "compare while off");
		apb(1'b1, off_irq_mask, 32'h1);
		// bench acts as privileged software, default status untouched
		apb(1'b1, off_ctrl, 32'h00f0_0001);
		chk({31'h0, irq}, 32'h1, "enable irq");
		apb(1'b1, off_irq_status, 32'h1);
		chk({31'h0, irq}, 32'h0, "enable irq clear");
		for (int r = 0; r < 4; r++)
		begin
			// mode bits from the last pass would sit beside the flags
			apb(1'b1, off_fpscr, 32'h0);
			apb(1'b1, off_event, 32'h100 | 32'(r));
			rd_chk(off_fpscr, {nzcv[r], 28'h0}, "compare flags");
			apb(1'b1, off_fpscr, 32'h0700_0000 | (32'(r) << 22));
			chk({27'h0, alt_half_precision, default_nan_mode, flush_to_zero, rounding_select},
				32'h1c | 32'(r), "mode controls");
		end
		apb(1'b1, off_fpscr, 32'hffff_ffff);
		rd_chk(off_fpscr, fpscr_keep, "reserved bits");
		apb(1'b1, off_fpscr, 32'h0);
		system_config_block <= 8'h80;
		apb(1'b1, off_event, 32'h0010_0200);
		chk({31'h0, fp_irq}, 32'h0, "masked flag");
		apb(1'b1, off_event, 32'h0080_0200);
		chk({31'h0, fp_irq}, 32'h1, "unmasked flag");
		rd_chk(off_fpscr, 32'h90, "sticky flags");
		// no save mode: handler clears flags directly
		apb(1'b1, off_fpscr, 32'h0);
		chk({31'h0, fp_irq}, 32'h0, "flags cleared");
		apb(1'b1, off_ctrl, 32'h00f0_0000);
		apb(1'b1, off_event, 32'h0010_0200);
		chk({31'h0, fp_irq}, 32'h0, "inexact unwired");
		apb(1'b1, off_event, 32'h0001_0200);
		chk({31'h0, fp_irq}, 32'h1, "invalid wired");
		apb(1'b1, off_ctrl, 32'h40f0_0000);
		apb(1'b0, off_fpscr, 32'h0);
		rd_chk(off_fpscr, reset_zero, "lazy clear");
		apb(1'b1, off_ctrl, 32'h80f0_0000);
		apb(1'b1, off_event, 32'h0004_0200);
		apb(1'b0, off_fpscr, 32'h0);
		rd_chk(off_fpscr, reset_zero, "auto clear");
		rd_chk(8'h20, reset_zero, "unmapped read");
		chk({31'h0, err}, 32'h1, "unmapped error");
		give_verdict();
	end
endmodule
